// ===== dfg_top.sv
// Diagnostic frame generator with APB register file and byte-wide tx stream
// Assumes PHY tx takes one byte per pclk; MAC data arrives synchronous to pclk
`timescale 1ns/10ps

// Function
// - Interrupt only when generator enable bit set
// - Subsystem mask bit gates output interrupt
// - Latched status bit shows generator interrupt
// - Sixteen-bit data length, reset 0x6B
// - Frame adds addresses, length, FCS: plus 18
// - Idle gap bytes equal gap field
// - Upper count register holds bits 31:16
// - Lower count register bits 15:0, reset 0x100
// - Count restarts from zero on enable/restart
// - Done flag reads one after burst
// - Done stays until read, read clears
// - Enabled generator replaces MAC as tx source
// - Control field selects payload content
// - Continuous bit runs until the stop code is written, else one burst
// - Restart bit restarts, self clears
module dfg_top (
    input wire logic pclk, // Clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] mac_txd, // MAC tx byte
    input wire logic mac_tx_en, // MAC tx valid
    output logic [7:0] phy_txd, // Byte to PHY
    output logic phy_tx_en, // Byte valid to PHY
    output logic irq // Subsystem interrupt, level
);
    // Registers
    logic gen_source_enable_q;
    logic [2:0] gen_payload_select_q;
    logic gen_restart_bit_q;
    logic gen_continuous_select_q;
    logic gen_irq_enable_q;
    logic [15:0] gen_data_length_q;
    logic [15:0] gen_gap_length_q;
    logic [15:0] gen_count_upper_q;
    logic [15:0] gen_count_lower_q;
    logic gen_complete_flag_q;
    logic diag_clock_enable_q;
    logic checker_gen_irq_mask_bit_q;
    logic checker_gen_irq_status_bit_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [7:0] phy_txd_q;
    logic phy_tx_en_q;
    logic irq_q;
    logic run_q;
    logic stop_q;
    dfg_pkg::dfg_state_type state_q;
    logic [15:0] byte_cnt_q;
    logic [31:0] frame_cnt_q;
    logic [7:0] decr_q;

    // Decode: first access cycle answers, so pready is asserted one cycle after penable rises
    wire access = psel && penable && !pready_q;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire [15:0] idx = paddr[17:2];
    wire aligned = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0);
    wire hit_en = aligned && (idx == dfg_pkg::IDX_SOURCE_ENABLE);
    wire hit_ctl = aligned && (idx == dfg_pkg::IDX_CONTROL);
    wire hit_cont = aligned && (idx == dfg_pkg::IDX_CONTINUOUS);
    wire hit_irqen = aligned && (idx == dfg_pkg::IDX_IRQ_ENABLE);
    wire hit_len = aligned && (idx == dfg_pkg::IDX_DATA_LENGTH);
    wire hit_gap = aligned && (idx == dfg_pkg::IDX_GAP_LENGTH);
    wire hit_cup = aligned && (idx == dfg_pkg::IDX_COUNT_UPPER);
    wire hit_clo = aligned && (idx == dfg_pkg::IDX_COUNT_LOWER);
    wire hit_done = aligned && (idx == dfg_pkg::IDX_COMPLETE_FLAG);
    wire hit_diag = aligned && (idx == dfg_pkg::IDX_DIAG_CLOCK);
    wire hit_mask = aligned && (idx == dfg_pkg::IDX_SUBSYS_MASK);
    wire hit_stat = aligned && (idx == dfg_pkg::IDX_SUBSYS_STATUS);
    wire hit_txs = aligned && (idx == dfg_pkg::IDX_TX_STATUS);
    wire hit_any = hit_en | hit_ctl | hit_cont | hit_irqen | hit_len | hit_gap | hit_cup | hit_clo
                   | hit_done | hit_diag | hit_mask | hit_stat | hit_txs;

    // Read mux, reserved bits zero
    logic [31:0] rdata;
    always_comb begin
        if (hit_en) begin
            rdata = {31'h0, gen_source_enable_q};
        end else if (hit_ctl) begin
            rdata = {28'h0, gen_restart_bit_q, gen_payload_select_q};
        end else if (hit_cont) begin
            rdata = {31'h0, gen_continuous_select_q};
        end else if (hit_irqen) begin
            rdata = {31'h0, gen_irq_enable_q};
        end else if (hit_len) begin
            rdata = {16'h0, gen_data_length_q};
        end else if (hit_gap) begin
            rdata = {16'h0, gen_gap_length_q};
        end else if (hit_cup) begin
            rdata = {16'h0, gen_count_upper_q};
        end else if (hit_clo) begin
            rdata = {16'h0, gen_count_lower_q};
        end else if (hit_done) begin
            rdata = {31'h0, gen_complete_flag_q};
        end else if (hit_diag) begin
            rdata = {31'h0, diag_clock_enable_q};
        end else if (hit_mask) begin
            rdata = {31'h0, checker_gen_irq_mask_bit_q};
        end else if (hit_stat) begin
            rdata = {31'h0, checker_gen_irq_status_bit_q};
        end else if (hit_txs) begin
            rdata = {29'h0, stop_q, run_q, phy_tx_en_q};
        end else begin
            rdata = 32'h0;
        end
    end

    // Generator control terms
    wire active = gen_source_enable_q && diag_clock_enable_q;
    wire [31:0] target = {gen_count_upper_q, gen_count_lower_q};
    wire start = wr && hit_ctl && pwdata[dfg_pkg::RESTART_POS];
    wire enable_rise = wr && hit_en && pwdata[0] && !gen_source_enable_q;
    // Launch looks at the registers before this write; restart needs the source already enabled
    wire launch = ((start && gen_source_enable_q) || enable_rise) && diag_clock_enable_q
                  && !(wr && hit_ctl && pwdata[2:0] == dfg_pkg::PL_STOP);
    wire [15:0] data_end = gen_data_length_q - 16'h1;
    wire last_fcs = (state_q == dfg_pkg::ST_FCS) && (byte_cnt_q == dfg_pkg::FCS_BYTES - 16'h1);
    wire [31:0] frames_done = frame_cnt_q + 32'h1;
    wire burst_end = last_fcs && !gen_continuous_select_q && (frames_done >= target);
    wire finished = burst_end && run_q;
    wire gen_irq_event = finished && gen_irq_enable_q;
    wire sending = (state_q == dfg_pkg::ST_HEADER) || (state_q == dfg_pkg::ST_DATA)
                   || (state_q == dfg_pkg::ST_FCS);

    // Header byte: addresses then length field big-endian
    wire [15:0] hdr_len_bytes = gen_data_length_q;
    wire [7:0] hdr_byte = (byte_cnt_q < 16'h0006) ? dfg_pkg::DEST_BYTE :
                          (byte_cnt_q < dfg_pkg::ADDR_BYTES) ? dfg_pkg::SRC_BYTE :
                          (byte_cnt_q == dfg_pkg::ADDR_BYTES) ? hdr_len_bytes[15:8] : hdr_len_bytes[7:0];

    // Payload byte per content select
    wire [7:0] rnd_byte;
    wire [7:0] data_byte = (gen_payload_select_q == dfg_pkg::PL_ZEROS) ? 8'h00 :
                           (gen_payload_select_q == dfg_pkg::PL_ONES) ? 8'hff :
                           (gen_payload_select_q == dfg_pkg::PL_ALT55) ? 8'h55 :
                           (gen_payload_select_q == dfg_pkg::PL_DECR) ? decr_q : rnd_byte;

    // CRC covers header and data
    wire [31:0] fcs;
    wire [1:0] fcs_sel = byte_cnt_q[1:0];
    wire [7:0] fcs_byte = fcs[8 * fcs_sel +: 8];
    wire [7:0] gen_byte = (state_q == dfg_pkg::ST_HEADER) ? hdr_byte :
                          (state_q == dfg_pkg::ST_DATA) ? data_byte : fcs_byte;
    wire crc_adv = (state_q == dfg_pkg::ST_HEADER) || (state_q == dfg_pkg::ST_DATA);
    // Clear also between back-to-back frames with no gap, and on a restart mid frame
    wire crc_clear = (state_q == dfg_pkg::ST_IDLE) || (state_q == dfg_pkg::ST_GAP) || last_fcs || launch;

    dfg_crc u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .clear(crc_clear),
        .advance(crc_adv),
        .byte_in(gen_byte),
        .fcs(fcs)
    );

    dfg_lfsr u_lfsr (
        .pclk(pclk),
        .presetn(presetn),
        .advance(state_q == dfg_pkg::ST_DATA),
        .rnd_byte(rnd_byte)
    );

    // APB writes, restart self clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_source_enable_q <= 1'b0;
            gen_payload_select_q <= dfg_pkg::PAYLOAD_RST;
            gen_restart_bit_q <= 1'b0;
            gen_continuous_select_q <= 1'b0;
            gen_irq_enable_q <= 1'b0;
            gen_data_length_q <= dfg_pkg::DATA_LENGTH_RST;
            gen_gap_length_q <= dfg_pkg::GAP_LENGTH_RST;
            gen_count_upper_q <= dfg_pkg::COUNT_UPPER_RST;
            gen_count_lower_q <= dfg_pkg::COUNT_LOWER_RST;
            diag_clock_enable_q <= 1'b0;
            checker_gen_irq_mask_bit_q <= 1'b0;
        end else begin
            gen_restart_bit_q <= 1'b0;
            if (wr && hit_en) gen_source_enable_q <= pwdata[0];
            if (wr && hit_ctl) gen_payload_select_q <= pwdata[2:0];
            if (wr && hit_cont) gen_continuous_select_q <= pwdata[0];
            if (wr && hit_irqen) gen_irq_enable_q <= pwdata[0];
            if (wr && hit_len) gen_data_length_q <= pwdata[15:0];
            if (wr && hit_gap) gen_gap_length_q <= pwdata[15:0];
            if (wr && hit_cup) gen_count_upper_q <= pwdata[15:0];
            if (wr && hit_clo) gen_count_lower_q <= pwdata[15:0];
            if (wr && hit_diag) diag_clock_enable_q <= pwdata[0];
            if (wr && hit_mask) checker_gen_irq_mask_bit_q <= pwdata[dfg_pkg::CHECKER_GEN_IRQ_POS];
        end
    end

    // APB answer and sticky flags; set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            gen_complete_flag_q <= 1'b0;
            checker_gen_irq_status_bit_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !hit_any;
            if (rd) prdata_q <= rdata;
            gen_complete_flag_q <= finished || (gen_complete_flag_q && !(rd && hit_done));
            checker_gen_irq_status_bit_q <= gen_irq_event
                || (checker_gen_irq_status_bit_q && !(rd && hit_stat));
            irq_q <= checker_gen_irq_status_bit_q && checker_gen_irq_mask_bit_q;
        end
    end

    // Frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= dfg_pkg::ST_IDLE;
            byte_cnt_q <= 16'h0;
            frame_cnt_q <= 32'h0;
            run_q <= 1'b0;
            stop_q <= 1'b0;
            decr_q <= 8'hff;
        end else if (launch) begin
            state_q <= dfg_pkg::ST_HEADER;
            byte_cnt_q <= 16'h0;
            frame_cnt_q <= 32'h0;
            run_q <= 1'b1;
            stop_q <= 1'b0;
            decr_q <= 8'hff;
        end else if (!active) begin
            state_q <= dfg_pkg::ST_IDLE;
            run_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            if (wr && hit_ctl && pwdata[2:0] == dfg_pkg::PL_STOP) stop_q <= 1'b1;
            case (state_q)
                dfg_pkg::ST_IDLE: begin
                    byte_cnt_q <= 16'h0;
                end
                dfg_pkg::ST_HEADER: begin
                    byte_cnt_q <= byte_cnt_q + 16'h1;
                    if (byte_cnt_q == dfg_pkg::HEADER_BYTES - 16'h1) begin
                        byte_cnt_q <= 16'h0;
                        decr_q <= 8'hff;
                        state_q <= (gen_data_length_q == 16'h0) ? dfg_pkg::ST_FCS : dfg_pkg::ST_DATA;
                    end
                end
                dfg_pkg::ST_DATA: begin
                    byte_cnt_q <= byte_cnt_q + 16'h1;
                    decr_q <= decr_q - 8'h1;
                    if (byte_cnt_q == data_end) begin
                        byte_cnt_q <= 16'h0;
                        state_q <= dfg_pkg::ST_FCS;
                    end
                end
                dfg_pkg::ST_FCS: begin
                    byte_cnt_q <= byte_cnt_q + 16'h1;
                    if (last_fcs) begin
                        byte_cnt_q <= 16'h0;
                        frame_cnt_q <= frames_done;
                        if (burst_end || stop_q) begin
                            state_q <= dfg_pkg::ST_IDLE;
                            run_q <= 1'b0;
                        end else begin
                            state_q <= (gen_gap_length_q == 16'h0) ? dfg_pkg::ST_HEADER : dfg_pkg::ST_GAP;
                        end
                    end
                end
                dfg_pkg::ST_GAP: begin
                    byte_cnt_q <= byte_cnt_q + 16'h1;
                    if (byte_cnt_q == gen_gap_length_q - 16'h1) begin
                        byte_cnt_q <= 16'h0;
                        state_q <= dfg_pkg::ST_HEADER;
                    end
                end
                default: begin
                    state_q <= dfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Transmit source select, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_txd_q <= 8'h0;
            phy_tx_en_q <= 1'b0;
        end else if (gen_source_enable_q) begin
            phy_txd_q <= sending ? gen_byte : 8'h0;
            phy_tx_en_q <= sending && active;
        end else begin
            phy_txd_q <= mac_txd;
            phy_tx_en_q <= mac_tx_en;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign phy_txd = phy_txd_q;
    assign phy_tx_en = phy_tx_en_q;
    assign irq = irq_q;
endmodule

// ===== dfg_pkg.sv
// Package for the diagnostic frame generator: register map, fields, resets
// Assumes APB with 32-bit data, registers at word index times four
package dfg_pkg;
    // Register indices as printed; byte address is index times four
    localparam logic [15:0] IDX_SOURCE_ENABLE = 16'h8020;
    localparam logic [15:0] IDX_CONTROL = 16'h8021;
    localparam logic [15:0] IDX_CONTINUOUS = 16'h8022;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h8023;
    localparam logic [15:0] IDX_DATA_LENGTH = 16'h8025;
    localparam logic [15:0] IDX_GAP_LENGTH = 16'h8026;
    localparam logic [15:0] IDX_COUNT_UPPER = 16'h8027;
    localparam logic [15:0] IDX_COUNT_LOWER = 16'h8028;
    localparam logic [15:0] IDX_COMPLETE_FLAG = 16'h8029;
    localparam logic [15:0] IDX_DIAG_CLOCK = 16'h8030;
    localparam logic [15:0] IDX_SUBSYS_MASK = 16'h8031;
    localparam logic [15:0] IDX_SUBSYS_STATUS = 16'h8032;
    localparam logic [15:0] IDX_TX_STATUS = 16'h8033;

    // Field positions
    localparam int RESTART_POS = 3;
    localparam int CHECKER_GEN_IRQ_POS = 0;

    // Reset values
    localparam logic [15:0] DATA_LENGTH_RST = 16'h006b;
    localparam logic [15:0] GAP_LENGTH_RST = 16'h000c;
    localparam logic [15:0] COUNT_UPPER_RST = 16'h0000;
    localparam logic [15:0] COUNT_LOWER_RST = 16'h0100;
    localparam logic [2:0] PAYLOAD_RST = 3'h1;

    // Header and trailer byte counts
    localparam logic [15:0] ADDR_BYTES = 16'h000c;
    localparam logic [15:0] HEADER_BYTES = 16'h000e;
    localparam logic [15:0] FCS_BYTES = 16'h0004;

    // Payload content codes
    localparam logic [2:0] PL_STOP = 3'h0;
    localparam logic [2:0] PL_RANDOM = 3'h1;
    localparam logic [2:0] PL_ZEROS = 3'h2;
    localparam logic [2:0] PL_ONES = 3'h3;
    localparam logic [2:0] PL_ALT55 = 3'h4;
    localparam logic [2:0] PL_DECR = 3'h5;

    // Fixed header address bytes and LFSR seed
    localparam logic [7:0] DEST_BYTE = 8'hff;
    localparam logic [7:0] SRC_BYTE = 8'h02;
    localparam logic [31:0] LFSR_SEED = 32'hace1_2468;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HEADER,
        ST_DATA,
        ST_FCS,
        ST_GAP
    } dfg_state_type;
endpackage

// ===== dfg_crc.sv
// Ethernet CRC-32 byte engine for the frame check sequence
// Assumes one byte per clock while advance is high
`timescale 1ns/10ps
module dfg_crc (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic clear, // Restart the remainder
    input wire logic advance, // Byte valid
    input wire logic [7:0] byte_in, // Byte to fold in
    output logic [31:0] fcs // Complemented remainder, bits in register order
);
    logic [31:0] crc_q;
    logic [31:0] crc_d;

    // Bitwise fold of one byte, LSB first
    always_comb begin
        crc_d = crc_q;
        for (int i = 0; i < 8; i++) begin
            if (crc_d[0] ^ byte_in[i]) begin
                crc_d = (crc_d >> 1) ^ 32'hedb8_8320;
            end else begin
                crc_d = crc_d >> 1;
            end
        end
    end

    // Remainder register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_q <= 32'hffff_ffff;
        end else if (clear) begin
            crc_q <= 32'hffff_ffff;
        end else if (advance) begin
            crc_q <= crc_d;
        end
    end

    assign fcs = ~crc_q;
endmodule

// ===== dfg_lfsr.sv
// Pseudo random byte source for random payload frames
// Assumes advance pulses once per data byte
`timescale 1ns/10ps
module dfg_lfsr (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic advance, // Step once
    output logic [7:0] rnd_byte // Current random byte
);
    logic [31:0] lfsr_q;

    // Galois LFSR, eight steps per byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= dfg_pkg::LFSR_SEED;
        end else if (advance) begin
            lfsr_q <= {lfsr_q[23:0], lfsr_q[31:24] ^ lfsr_q[21:14] ^ {lfsr_q[1:0], lfsr_q[7:2]}};
        end
    end

    assign rnd_byte = lfsr_q[7:0];
endmodule

// ===== dfg_phy_model.sv
// Sink model of the PHY transmit path: counts frames, bytes and idle gaps
// Assumes one byte per pclk while phy_tx_en is high
`timescale 1ns/10ps
module dfg_phy_model (
    input wire logic pclk, // Clock
    input wire logic [7:0] phy_txd, // Byte from the block
    input wire logic phy_tx_en // Byte valid
);
    int frames = 0;
    int len = 0;
    int last_len = 0;
    int gap = 0;
    int last_gap = 0;
    logic [7:0] fb [64];

    // Capture bytes of the current frame, close it on the first idle cycle
    always @(posedge pclk) begin
        if (phy_tx_en) begin
            if (len < 64) fb[len] <= phy_txd;
            if (len == 0) last_gap <= gap;
            len <= len + 1;
        end else if (len != 0) begin
            frames <= frames + 1;
            last_len <= len;
            len <= 0;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end
endmodule

// ===== dfg_top_chk.sv
// Checker for the frame generator top: APB answer timing, frame header, interrupt release
// Assumes it is bound to dfg_top and sees only its ports
`timescale 1ns/10ps
module dfg_top_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [7:0] mac_txd, // MAC byte
    input wire logic mac_tx_en, // MAC valid
    input wire logic [7:0] phy_txd, // PHY byte
    input wire logic phy_tx_en, // PHY valid
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer: one wait state, one-cycle pulse, error only with ready
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    // Generated frames open with destination then source address bytes
    a_header_dest: assert property ($rose(phy_tx_en) && !$past(mac_tx_en) |->
        (phy_tx_en && phy_txd == dfg_pkg::DEST_BYTE)[*6]) else $error("bad destination bytes");
    a_header_src: assert property ($rose(phy_tx_en) && !$past(mac_tx_en) |-> ##6
        (phy_tx_en && phy_txd == dfg_pkg::SRC_BYTE)[*6]) else $error("bad source bytes");
    // Interrupt drops only after a register access
    a_irq_fall_read: assert property ($fell(irq) |-> $past(psel && penable, 2))
        else $error("irq fell without access");
endmodule

// ===== test_dfg_top.sv
// Testbench for the frame generator: register resets, bursts, payloads, interrupts
// Assumes the PHY sink model and the checker bound below
`timescale 1ns/10ps
module test_dfg_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] mac_txd = 8'h0;
    logic mac_tx_en = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] phy_txd;
    logic phy_tx_en;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int compares = 0;
    int miscompares = 0;
    int f1;
    localparam logic [15:0] RIDX [7] = '{dfg_pkg::IDX_IRQ_ENABLE, dfg_pkg::IDX_DATA_LENGTH,
        dfg_pkg::IDX_GAP_LENGTH, dfg_pkg::IDX_COUNT_UPPER, dfg_pkg::IDX_COUNT_LOWER,
        dfg_pkg::IDX_COMPLETE_FLAG, dfg_pkg::IDX_CONTROL};
    localparam logic [15:0] RVAL [7] = '{16'h0, 16'h6b, 16'hc, 16'h0, 16'h100, 16'h0, 16'h1};
    localparam logic [7:0] PEXP [6] = '{8'h0, 8'h0, 8'h0, 8'hff, 8'h55, 8'hff};

    dfg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en), .irq(irq));
    dfg_phy_model phy_u (.pclk(pclk), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference Ethernet CRC-32 over the first n captured bytes
    function automatic logic [31:0] ref_fcs(input int n);
        logic [31:0] c;
        c = 32'hffff_ffff;
        for (int k = 0; k < n; k++) begin
            for (int b = 0; b < 8; b++) begin
                c = (c[0] ^ phy_u.fb[k][b]) ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(name, rdat, exp);
    endtask

    // Start by one write, wait for n frames, then make sure the burst stopped
    task automatic run(input logic [15:0] idx, input logic [31:0] val, input int n);
        int f0;
        f0 = phy_u.frames;
        wr(idx, val);
        while (phy_u.frames < f0 + n) @(posedge pclk);
        repeat (60) @(posedge pclk);
        check("frame count", phy_u.frames - f0, n);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk("reset", RIDX[i], {16'h0, RVAL[i]});
        apb(1'b0, 16'h8024, 32'h0);
        check("unmapped data", rdat, 32'h0);
        check("unmapped error", {31'h0, rerr}, 32'h1);
        wr(dfg_pkg::IDX_COUNT_UPPER, 32'hffff_ffff);
        rdchk("count upper", dfg_pkg::IDX_COUNT_UPPER, 32'h0000_ffff);
        wr(dfg_pkg::IDX_COUNT_UPPER, 32'h0);
        @(posedge pclk);
        mac_txd <= 8'h5a;
        mac_tx_en <= 1'b1;
        @(posedge pclk);
        mac_tx_en <= 1'b0;
        @(negedge pclk);
        check("mac pass", {23'h0, phy_tx_en, phy_txd}, 32'h15a);
        // Burst of three short decrementing frames
        wr(dfg_pkg::IDX_DATA_LENGTH, 32'h4);
        wr(dfg_pkg::IDX_GAP_LENGTH, 32'h3);
        wr(dfg_pkg::IDX_COUNT_LOWER, 32'h3);
        wr(dfg_pkg::IDX_IRQ_ENABLE, 32'h1);
        wr(dfg_pkg::IDX_SUBSYS_MASK, 32'h1);
        wr(dfg_pkg::IDX_DIAG_CLOCK, 32'h1);
        wr(dfg_pkg::IDX_CONTROL, {29'h0, dfg_pkg::PL_DECR});
        run(dfg_pkg::IDX_SOURCE_ENABLE, 32'h1, 3);
        check("frame length", phy_u.last_len, 22);
        check("gap length", phy_u.last_gap, 3);
        check("length field", {phy_u.fb[12], phy_u.fb[13]}, 32'h4);
        check("fcs", {phy_u.fb[21], phy_u.fb[20], phy_u.fb[19], phy_u.fb[18]}, ref_fcs(18));
        for (int i = 0; i < 4; i++) check("decrement", phy_u.fb[14 + i], 255 - i);
        check("irq level", {31'h0, irq}, 32'h1);
        rdchk("done set", dfg_pkg::IDX_COMPLETE_FLAG, 32'h1);
        rdchk("done cleared", dfg_pkg::IDX_COMPLETE_FLAG, 32'h0);
        rdchk("status latched", dfg_pkg::IDX_SUBSYS_STATUS, 32'h1);
        @(negedge pclk);
        check("irq after read", {31'h0, irq}, 32'h0);
        // Payload codes 1 to 5 by restart, one frame each
        wr(dfg_pkg::IDX_COUNT_LOWER, 32'h1);
        for (int c = 1; c < 6; c++) begin
            run(dfg_pkg::IDX_CONTROL, 32'h8 | c, 1);
            if (c != 1) check("payload", phy_u.fb[14], PEXP[c]);
            rdchk("restart clears", dfg_pkg::IDX_CONTROL, c);
            rdchk("done again", dfg_pkg::IDX_COMPLETE_FLAG, 32'h1);
        end
        // Interrupt enable and subsystem mask
        rdchk("status again", dfg_pkg::IDX_SUBSYS_STATUS, 32'h1);
        wr(dfg_pkg::IDX_IRQ_ENABLE, 32'h0);
        run(dfg_pkg::IDX_CONTROL, 32'hd, 1);
        rdchk("no status", dfg_pkg::IDX_SUBSYS_STATUS, 32'h0);
        wr(dfg_pkg::IDX_IRQ_ENABLE, 32'h1);
        wr(dfg_pkg::IDX_SUBSYS_MASK, 32'h0);
        run(dfg_pkg::IDX_CONTROL, 32'hd, 1);
        check("masked irq", {31'h0, irq}, 32'h0);
        rdchk("status set", dfg_pkg::IDX_SUBSYS_STATUS, 32'h1);
        rdchk("done masked", dfg_pkg::IDX_COMPLETE_FLAG, 32'h1);
        // Continuous mode, then stop code
        wr(dfg_pkg::IDX_SUBSYS_MASK, 32'h1);
        wr(dfg_pkg::IDX_CONTINUOUS, 32'h1);
        f1 = phy_u.frames;
        wr(dfg_pkg::IDX_CONTROL, 32'ha);
        while (phy_u.frames < f1 + 4) @(posedge pclk);
        check("continuous irq", {31'h0, irq}, 32'h0);
        rdchk("continuous done", dfg_pkg::IDX_COMPLETE_FLAG, 32'h0);
        wr(dfg_pkg::IDX_CONTROL, 32'h0);
        repeat (60) @(posedge pclk);
        f1 = phy_u.frames;
        repeat (60) @(posedge pclk);
        check("stopped", phy_u.frames, f1);
        rdchk("stop done", dfg_pkg::IDX_COMPLETE_FLAG, 32'h0);
        // MAC data must not reach the PHY while the generator owns the path
        mac_tx_en <= 1'b1;
        repeat (2) @(posedge pclk);
        check("mac blocked", {31'h0, phy_tx_en}, 32'h0);
        mac_tx_en <= 1'b0;
        close_out();
    end
endmodule

bind dfg_top dfg_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en), .irq(irq));
